// *** rtl/imager_board_default_loader.sv ***
`timescale 1ns/1ps
`include "board_loader_map.svh"
// Contract
// - Reset internally on power, button, remote reset
// - Load front-end first, then timing generator
// - Afterwards monitor timing generator and serial input
// - Free-running: integration one frame to one eighth
// - Still mode uses different integration line numbers
// - Shutter clears charge during previous frame readout
// - Front-end 0=128, 3=8, 4..7=43
// - Front-end gain 260 high, 350 low
// - Front-end clamp register written as 96
// - Frame pointer 0 normal, 1 still, 2 binning
// - Pixels per line 1664 single, 832 dual
// - Line valid quad 0, start 9, end set
// - Black clamp window per channel count
// - Host may change clamp over serial later
// - All 24 mA drive enables written zero
// - Delay-locked-loop range written as eight
// - Pixel data clock 50 ns period
// - Power-good rising edge restarts loading
// - Remote reset high holds generator reset; fall reloads
// - Channel switch high selects dual output
// - Capture switch high selects still mode
module imager_board_default_loader (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic power_good_delayed,
    input wire logic reset_pushbutton,
    input wire logic remote_reset_input,
    input wire logic sensor_variant_switch,
    input wire logic channel_count_switch,
    input wire logic binning_select_switch,
    input wire logic capture_mode_switch,
    input wire logic [4:0] integration_select_inputs,
    input wire logic host_sload,
    input wire logic host_sdata,
    input wire logic host_sclock,
    input wire logic tg_line_valid,
    input wire logic tg_frame_valid,
    output logic sdata,
    output logic sclock,
    output logic sload_afe1_n,
    output logic sload_afe2_n,
    output logic sload_tg_n,
    output logic timing_gen_async_reset_n,
    output logic pixel_data_clock,
    output logic load_busy,
    output logic load_done,
    output logic tg_active
);
    import board_loader_pkg::*;

    localparam int PIX_PAIR = `PIX_PAIR_CYC;
    localparam int TOTAL_WORDS = `AFE_WORDS + `TG_WORDS;

    // Every pin input is brought into the clock domain by two flops.
    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    logic [12:0] sync_next;
    logic [12:0] pins;
    assign pins = {power_good_delayed, reset_pushbutton, remote_reset_input,
        host_sload, host_sdata, host_sclock, tg_line_valid, tg_frame_valid,
        sensor_variant_switch, channel_count_switch, binning_select_switch,
        capture_mode_switch, 1'b0};

    always_comb begin
        sync_next = pins;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end

    logic pg_s, btn_s, rr_s, hl_s, hd_s, hc_s, lv_s, fv_s;
    logic var_s, ch_s, bin_s, cap_s;
    assign {pg_s, btn_s, rr_s, hl_s, hd_s, hc_s, lv_s, fv_s,
        var_s, ch_s, bin_s, cap_s} = sync2_reg[12:1];

    // Integration select is a slow bus; it is captured only at load start.
    logic [4:0] isel1_reg;
    logic [4:0] isel2_reg;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            isel1_reg <= '0;
            isel2_reg <= '0;
        end else begin
            isel1_reg <= integration_select_inputs;
            isel2_reg <= isel1_reg;
        end
    end

    // Edge history for the restart sources.
    logic pg_d_reg, btn_d_reg, rr_d_reg;
    logic restart;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pg_d_reg <= 1'b0;
            btn_d_reg <= 1'b0;
            rr_d_reg <= 1'b0;
        end else begin
            pg_d_reg <= pg_s;
            btn_d_reg <= btn_s;
            rr_d_reg <= rr_s;
        end
    end
    // A button press is its rising edge; the remote line acts on its fall.
    assign restart = (pg_s & ~pg_d_reg)
        | (btn_s & ~btn_d_reg)
        | (~rr_s & rr_d_reg);

    // Remote reset level drives the generator reset directly, held low.
    assign timing_gen_async_reset_n = ~rr_s;

    // Pixel clock alternates 2- and 3-cycle periods, 50 ns on average.
    logic [7:0] pix_cnt_reg, pix_cnt_next;
    logic pix_reg, pix_next;
    always_comb begin
        pix_cnt_next = pix_cnt_reg + 8'h01;
        pix_next = ~pix_reg;
        if (pix_cnt_reg == 8'(PIX_PAIR - 1)) begin
            pix_cnt_next = 8'h00;
            pix_next = pix_reg;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pix_cnt_reg <= 8'h00;
            pix_reg <= 1'b0;
        end else begin
            pix_cnt_reg <= pix_cnt_next;
            pix_reg <= pix_next;
        end
    end
    assign pixel_data_clock = pix_reg;

    // Integration line lookup; still mode uses the longer flush table.
    function automatic logic [15:0] intg_line_of(input logic [2:0] sel,
        input logic still);
        logic [15:0] r;
        r = 16'h0ff8;
        if (sel != 3'h0) begin
            // Free: 1216 - 152*sel. Still: 3648 - 456*sel.
            r = still ? 16'(16'h0e40 - 16'(sel) * 16'h01c8)
                : 16'(16'h04c0 - 16'(sel) * 16'h0098);
        end
        intg_line_of = r;
    endfunction

    // Snapshot of switch settings taken when a load begins.
    logic var_reg, ch_reg, var_next, ch_next;
    logic [15:0] ft_reg, ft_next, il_reg, il_next;

    // Load sequencer state.
    load_state_e st_reg, st_next;
    logic [4:0] idx_reg, idx_next;
    logic [5:0] bit_reg, bit_next;
    logic [3:0] div_reg, div_next;
    ser_word_t sh_reg, sh_next;
    logic sck_reg, sck_next;
    logic [2:0] ds_reg, ds_next;
    logic started_reg, started_next;
    ser_word_t rom_word;

    default_rom rom_i (
        .core_clk(core_clk),
        .nrst(nrst),
        .addr(idx_next),
        .variant_hi(var_reg),
        .dual_ch(ch_reg),
        .frame_ptr(ft_reg),
        .intg_line(il_reg),
        .word(rom_word)
    );

    always_comb begin
        st_next = st_reg;
        idx_next = idx_reg;
        bit_next = bit_reg;
        div_next = div_reg;
        sh_next = sh_reg;
        sck_next = sck_reg;
        ds_next = ds_reg;
        var_next = var_reg;
        ch_next = ch_reg;
        ft_next = ft_reg;
        il_next = il_reg;
        started_next = started_reg;
        // A restart aborts any load and begins again from the first word.
        if (restart || (!started_reg && pg_s)) begin
            started_next = 1'b1;
            st_next = ST_FETCH;
            idx_next = 5'h00;
            sck_next = 1'b0;
            ds_next = 3'h0;
            // Switches are sampled here only and held for the whole load.
            var_next = var_s;
            ch_next = ch_s;
            ft_next = bin_s ? `FT_BIN
                : (cap_s ? `FT_STILL : `FT_NORMAL);
            il_next = intg_line_of(isel2_reg[2:0], cap_s);
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    st_next = ST_IDLE;
                end
                ST_FETCH: begin
                    // Wait one cycle for registered table data.
                    st_next = ST_SHIFT;
                    sh_next = rom_word;
                    ds_next = rom_word[31:29];
                    bit_next = 6'h00;
                    div_next = 4'h0;
                end
                ST_SHIFT: begin
                    div_next = div_reg + 4'h1;
                    if (div_reg == 4'(`SER_HALF_CYC - 1)) begin
                        div_next = 4'h0;
                        sck_next = ~sck_reg;
                        // Data advances on the falling serial clock.
                        if (sck_reg) begin
                            sh_next = {sh_reg[30:0], 1'b0};
                            bit_next = bit_reg + 6'h01;
                            if (bit_reg == 6'(`SER_BITS - 1)) begin
                                st_next = ST_GAP;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    ds_next = 3'h0;
                    if (idx_reg == 5'(TOTAL_WORDS - 1)) begin
                        st_next = ST_DONE;
                    end else begin
                        idx_next = idx_reg + 5'h01;
                        st_next = ST_FETCH;
                    end
                end
                ST_DONE: begin
                    st_next = ST_DONE;
                end
                default: st_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_IDLE;
            idx_reg <= 5'h00;
            bit_reg <= 6'h00;
            div_reg <= 4'h0;
            sh_reg <= '0;
            sck_reg <= 1'b0;
            ds_reg <= 3'h0;
            var_reg <= 1'b0;
            ch_reg <= 1'b0;
            ft_reg <= 16'h0000;
            il_reg <= 16'h0000;
            started_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            bit_reg <= bit_next;
            div_reg <= div_next;
            sh_reg <= sh_next;
            sck_reg <= sck_next;
            ds_reg <= ds_next;
            var_reg <= var_next;
            ch_reg <= ch_next;
            ft_reg <= ft_next;
            il_reg <= il_next;
            started_reg <= started_next;
        end
    end

    logic loading;
    assign loading = (st_reg != ST_DONE);
    assign load_busy = loading;
    assign load_done = (st_reg == ST_DONE);

    // After loading the host serial stream is passed through, steered
    // by its first three bits; host bits are ignored while loading.
    logic [1:0] hcnt_reg, hcnt_next;
    logic [2:0] hds_reg, hds_next;
    logic hc_d_reg;
    always_comb begin
        hcnt_next = hcnt_reg;
        hds_next = hds_reg;
        if (loading || hl_s) begin
            hcnt_next = 2'h0;
            hds_next = 3'h0;
        end else if (hc_s && !hc_d_reg && hcnt_reg != 2'h3) begin
            hds_next = {hds_reg[1:0], hd_s};
            hcnt_next = hcnt_reg + 2'h1;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hcnt_reg <= 2'h0;
            hds_reg <= 3'h0;
            hc_d_reg <= 1'b0;
        end else begin
            hcnt_reg <= hcnt_next;
            hds_reg <= hds_next;
            hc_d_reg <= hc_s;
        end
    end

    // Output mux: loader owns the bus while loading, host afterwards.
    logic [2:0] sel_ds;
    logic host_sel;
    assign host_sel = !loading && (hcnt_reg == 2'h3);
    assign sel_ds = loading ? ((st_reg == ST_SHIFT) ? ds_reg : 3'h0)
        : (host_sel ? hds_reg : 3'h0);
    assign sdata = loading ? sh_reg[31] : hd_s;
    assign sclock = loading ? sck_reg : hc_s;
    // At most one target strobe is active at a time.
    assign sload_afe1_n = ~(sel_ds == `DS_AFE1);
    assign sload_afe2_n = ~(sel_ds == `DS_AFE2);
    assign sload_tg_n = ~(sel_ds == `DS_TG);

    // Background activity monitor of the timing generator.
    assign tg_active = load_done & (lv_s | fv_s);

    // The operator must reset after changing integration select.
endmodule

// *** rtl/board_loader_map.svh ***
`ifndef BOARD_LOADER_MAP_SVH
`define BOARD_LOADER_MAP_SVH
// Core clock rate and pixel clock period.
`define CORE_CLK_MHZ 50
`define PIX_PERIOD_NS 50
// Core cycles in two pixel periods; one toggle in each run is held.
`define PIX_PAIR_CYC ((`PIX_PERIOD_NS * `CORE_CLK_MHZ) / 500)
// Serial bit clock divider: core cycles per serial clock half period.
`define SER_HALF_CYC 4
// Serial word layout: 3 device-select bits, 13 address bits, 16 data bits.
`define SER_BITS 32
`define DS_AFE1 3'h1
`define DS_AFE2 3'h2
`define DS_TG 3'h3
// Front-end defaults.
`define AFE_OPERATION 16'h0080
`define AFE_VGA_HI 16'h0104
`define AFE_VGA_LO 16'h015e
`define AFE_CLAMP 16'h0060
`define AFE_CONTROL 16'h0008
`define AFE_PIXEL_GAIN_AMP 16'h002b
`define AFE_WORDS 8
// Timing generator entry indices and defaults.
`define TG_FRAME_PTR 13'h0000
`define TG_PIX_LINE 13'h0010
`define TG_LV_START 13'h0011
`define TG_LV_QUAD 13'h0012
`define TG_LV_END 13'h0013
`define TG_CLP1_START 13'h0014
`define TG_CLP1_END 13'h0015
`define TG_DRIVE_EN 13'h0016
`define TG_DLL_RANGE 13'h0017
`define TG_INTG_LINE 13'h0040
`define TG_WORDS 10
`define FT_NORMAL 16'h0000
`define FT_STILL 16'h0001
`define FT_BIN 16'h0002
`define PPL_1CH 16'h0680
`define PPL_2CH 16'h0340
`define LV_START 16'h0009
`define LV_QUAD 16'h0000
`define LV_END_1CH 16'h0674
`define LV_END_2CH 16'h033a
`define CLP_S_1CH 16'h065e
`define CLP_E_1CH 16'h0668
`define CLP_S_2CH 16'h033c
`define CLP_E_2CH 16'h033d
`define DRIVE_24MA 16'h0000
`define DLL_RANGE 16'h0008
`endif

// *** rtl/board_loader_pkg.sv ***
package board_loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_SHIFT = 3'h3,
        ST_GAP = 3'h2,
        ST_DONE = 3'h6
    } load_state_e;
    typedef logic [31:0] ser_word_t;
endpackage

// *** rtl/default_rom.sv ***
`timescale 1ns/1ps
`include "board_loader_map.svh"
// Table of default words; read data comes out of a register.
module default_rom (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [4:0] addr,
    input wire logic variant_hi,
    input wire logic dual_ch,
    input wire logic [15:0] frame_ptr,
    input wire logic [15:0] intg_line,
    output board_loader_pkg::ser_word_t word
);
    import board_loader_pkg::*;
    ser_word_t word_reg;
    ser_word_t word_next;

    // Build a serial word from select, address and data.
    function automatic ser_word_t mk(input logic [2:0] ds,
        input logic [12:0] a, input logic [15:0] d);
        mk = {ds, a, d};
    endfunction

    // Front-end words first at indices 0-7, then the timing generator.
    always_comb begin
        word_next = '0;
        unique case (addr)
            5'h00: word_next = mk(`DS_AFE1, 13'h0000, `AFE_OPERATION);
            5'h01: word_next = mk(`DS_AFE1, 13'h0001,
                variant_hi ? `AFE_VGA_HI : `AFE_VGA_LO);
            5'h02: word_next = mk(`DS_AFE1, 13'h0002, `AFE_CLAMP);
            5'h03: word_next = mk(`DS_AFE1, 13'h0003, `AFE_CONTROL);
            5'h04: word_next = mk(`DS_AFE1, 13'h0004, `AFE_PIXEL_GAIN_AMP);
            5'h05: word_next = mk(`DS_AFE1, 13'h0005, `AFE_PIXEL_GAIN_AMP);
            5'h06: word_next = mk(`DS_AFE1, 13'h0006, `AFE_PIXEL_GAIN_AMP);
            5'h07: word_next = mk(`DS_AFE1, 13'h0007, `AFE_PIXEL_GAIN_AMP);
            5'h08: word_next = mk(`DS_TG, `TG_FRAME_PTR, frame_ptr);
            5'h09: word_next = mk(`DS_TG, `TG_PIX_LINE,
                dual_ch ? `PPL_2CH : `PPL_1CH);
            5'h0a: word_next = mk(`DS_TG, `TG_LV_START, `LV_START);
            5'h0b: word_next = mk(`DS_TG, `TG_LV_QUAD, `LV_QUAD);
            5'h0c: word_next = mk(`DS_TG, `TG_LV_END,
                dual_ch ? `LV_END_2CH : `LV_END_1CH);
            5'h0d: word_next = mk(`DS_TG, `TG_CLP1_START,
                dual_ch ? `CLP_S_2CH : `CLP_S_1CH);
            5'h0e: word_next = mk(`DS_TG, `TG_CLP1_END,
                dual_ch ? `CLP_E_2CH : `CLP_E_1CH);
            5'h0f: word_next = mk(`DS_TG, `TG_DRIVE_EN, `DRIVE_24MA);
            5'h10: word_next = mk(`DS_TG, `TG_DLL_RANGE, `DLL_RANGE);
            5'h11: word_next = mk(`DS_TG, `TG_INTG_LINE, intg_line);
            default: word_next = '0;
        endcase
    end

    // Registered read port.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            word_reg <= '0;
        end else begin
            word_reg <= word_next;
        end
    end

    assign word = word_reg;
endmodule

// *** test/loader_monitor.sv ***
`timescale 1ns/1ps
// Pin-level checks of the default loader, all in the core clock domain.
module loader_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic power_good_delayed,
    input wire logic reset_pushbutton,
    input wire logic remote_reset_input,
    input wire logic sclock,
    input wire logic sload_afe1_n,
    input wire logic sload_afe2_n,
    input wire logic sload_tg_n,
    input wire logic timing_gen_async_reset_n,
    input wire logic pixel_data_clock,
    input wire logic load_busy,
    input wire logic load_done,
    input wire logic tg_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // A timing generator word opens with its strobe falling and holds it.
    sequence s_tg_open;
        $fell(sload_tg_n);
    endsequence
    sequence s_tg_hold;
        (!sload_tg_n) [*8];
    endsequence
    property p_strobe_hold;
        s_tg_open |=> s_tg_hold;
    endproperty
    property p_one_strobe;
        load_busy |-> $countones({sload_afe1_n, sload_afe2_n, sload_tg_n}) >= 2;
    endproperty
    // Serial clock high phase lasts four core cycles.
    property p_sclk_half;
        $rose(sclock) && load_busy |=> sclock [*3];
    endproperty
    // The synchroniser needs two cycles, so four cycles of level suffice.
    property p_arst_hold;
        remote_reset_input [*4] |-> !timing_gen_async_reset_n;
    endproperty
    property p_arst_free;
        !remote_reset_input [*4] |-> timing_gen_async_reset_n;
    endproperty
    property p_button;
        $rose(reset_pushbutton) |-> ##[1:6] load_busy;
    endproperty
    property p_power_good;
        $rose(power_good_delayed) |-> ##[1:6] load_busy;
    endproperty
    property p_remote_fall;
        $fell(remote_reset_input) |-> ##[1:6] load_busy;
    endproperty
    property p_done_order;
        $fell(load_busy) |-> load_done && !$past(sload_tg_n, 2);
    endproperty
    property p_quiet_loading;
        !load_done |-> !tg_active;
    endproperty
    property p_pix_toggle;
        $past(nrst) && $stable(pixel_data_clock)
            |=> $changed(pixel_data_clock);
    endproperty

    a_strobe_hold: assert property (p_strobe_hold)
        else $error("timing generator strobe released early");
    a_one_strobe: assert property (p_one_strobe)
        else $error("more than one load strobe low");
    a_sclk_half: assert property (p_sclk_half)
        else $error("serial clock high phase too short");
    a_arst_hold: assert property (p_arst_hold)
        else $error("generator reset not held while remote reset high");
    a_arst_free: assert property (p_arst_free)
        else $error("generator reset low with remote reset low");
    a_button: assert property (p_button)
        else $error("button press did not start a load");
    a_power_good: assert property (p_power_good)
        else $error("power good rise did not start a load");
    a_remote_fall: assert property (p_remote_fall)
        else $error("remote reset fall did not start a load");
    a_done_order: assert property (p_done_order)
        else $error("load ended without done or generator word last");
    a_quiet_loading: assert property (p_quiet_loading)
        else $error("activity flagged before loading finished");
    a_pix_toggle: assert property (p_pix_toggle)
        else $error("pixel clock held for more than two cycles");
endmodule

// *** test/serial_far_end.sv ***
`timescale 1ns/1ps
// Behavioural front-end and timing generator: collects each serial word.
module serial_far_end (
    input wire logic core_clk,
    input wire logic sdata,
    input wire logic sclock,
    input wire logic sload_afe1_n,
    input wire logic sload_afe2_n,
    input wire logic sload_tg_n,
    input wire logic timing_gen_async_reset_n,
    output logic tg_line_valid,
    output logic tg_frame_valid
);
    logic [33:0] words[$];
    logic [31:0] shift_reg;
    logic [4:0] tick_reg = 5'h00;
    // Bits are taken on the rising serial clock while a strobe is low.
    always @(posedge sclock) begin
        if (!(sload_afe1_n & sload_afe2_n & sload_tg_n)) begin
            shift_reg <= {shift_reg[30:0], sdata};
        end
    end
    // A word ends when its strobe returns high; the target is kept too.
    always @(posedge sload_afe1_n) words.push_back({2'h1, shift_reg});
    always @(posedge sload_afe2_n) words.push_back({2'h2, shift_reg});
    always @(posedge sload_tg_n) words.push_back({2'h3, shift_reg});
    // Frame valid follows reset release; line valid toggles every 16 cycles.
    always @(posedge core_clk) begin
        tick_reg <= timing_gen_async_reset_n ? tick_reg + 5'h01 : 5'h00;
    end
    assign tg_line_valid = tick_reg[4];
    assign tg_frame_valid = timing_gen_async_reset_n;
endmodule

// *** test/imager_board_default_loader_test.sv ***
`timescale 1ns/1ps
`include "board_loader_map.svh"
module imager_board_default_loader_test;
    logic core_clk, nrst = 1'b0, power_good_delayed = 1'b1;
    logic reset_pushbutton = 1'b0, remote_reset_input = 1'b0;
    logic sensor_variant_switch = 1'b1, channel_count_switch = 1'b0;
    logic binning_select_switch = 1'b0, capture_mode_switch = 1'b0;
    logic [4:0] integration_select_inputs = 5'h00;
    logic host_sload = 1'b1, host_sdata = 1'b0, host_sclock = 1'b0;
    logic tg_line_valid, tg_frame_valid, sdata, sclock, load_busy;
    logic sload_afe1_n, sload_afe2_n, sload_tg_n, load_done, tg_active;
    logic timing_gen_async_reset_n, pixel_data_clock;
    int mismatches = 0, comparisons = 0;

    imager_board_default_loader i_dut (.core_clk(core_clk), .nrst(nrst),
        .power_good_delayed(power_good_delayed),
        .reset_pushbutton(reset_pushbutton),
        .remote_reset_input(remote_reset_input),
        .sensor_variant_switch(sensor_variant_switch),
        .channel_count_switch(channel_count_switch),
        .binning_select_switch(binning_select_switch),
        .capture_mode_switch(capture_mode_switch),
        .integration_select_inputs(integration_select_inputs),
        .host_sload(host_sload), .host_sdata(host_sdata),
        .host_sclock(host_sclock), .tg_line_valid(tg_line_valid),
        .tg_frame_valid(tg_frame_valid), .sdata(sdata), .sclock(sclock),
        .sload_afe1_n(sload_afe1_n), .sload_afe2_n(sload_afe2_n),
        .sload_tg_n(sload_tg_n),
        .timing_gen_async_reset_n(timing_gen_async_reset_n),
        .pixel_data_clock(pixel_data_clock), .load_busy(load_busy),
        .load_done(load_done), .tg_active(tg_active));
    serial_far_end i_far (.core_clk(core_clk), .sdata(sdata),
        .sclock(sclock), .sload_afe1_n(sload_afe1_n),
        .sload_afe2_n(sload_afe2_n), .sload_tg_n(sload_tg_n),
        .timing_gen_async_reset_n(timing_gen_async_reset_n),
        .tg_line_valid(tg_line_valid), .tg_frame_valid(tg_frame_valid));

    // Free-running clock at 50 MHz.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [33:0] exp,
                         input logic [33:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded waits; a hang in wait_done ends the run through the verdict.
    task automatic wait_busy();
        int n;
        for (n = 0; n < 20 && load_busy !== 1'b1; n++) @(negedge core_clk);
        check("load busy", 34'h1, {33'h0, load_busy});
    endtask
    task automatic wait_done();
        int n;
        for (n = 0; n < 9000 && load_done !== 1'b1; n++) @(negedge core_clk);
        if (load_done !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
    endtask

    // Expected words are built from the switch values seen at load start.
    task automatic check_load(input logic vhi, dual, bin, still,
                              input logic [2:0] sel);
        logic [15:0] v [0:17];
        logic [12:0] a [0:17];
        logic [15:0] intg;
        int i;
        intg = (sel == 3'h0) ? 16'h0ff8 : still ?
            16'h0e40 - 16'(sel) * 16'h01c8 : 16'h04c0 - 16'(sel) * 16'h0098;
        v = '{16'h0080, vhi ? 16'h0104 : 16'h015e, 16'h0060, 16'h0008,
            16'h002b, 16'h002b, 16'h002b, 16'h002b,
            bin ? 16'h0002 : still ? 16'h0001 : 16'h0000,
            dual ? 16'h0340 : 16'h0680, 16'h0009, 16'h0000,
            dual ? 16'h033a : 16'h0674, dual ? 16'h033c : 16'h065e,
            dual ? 16'h033d : 16'h0668, 16'h0000, 16'h0008, intg};
        a = '{13'h0, 13'h1, 13'h2, 13'h3, 13'h4, 13'h5, 13'h6, 13'h7,
            `TG_FRAME_PTR, `TG_PIX_LINE, `TG_LV_START, `TG_LV_QUAD,
            `TG_LV_END, `TG_CLP1_START, `TG_CLP1_END, `TG_DRIVE_EN,
            `TG_DLL_RANGE, `TG_INTG_LINE};
        check("word count", 34'h12, 34'(i_far.words.size()));
        for (i = 0; i < 18; i++) begin
            check($sformatf("word %0d", i), {i < 8 ? 5'h09 : 5'h1b, a[i],
                v[i]}, i_far.words[i]);
        end
    endtask

    task automatic t_power_up();
        wait_done();
        check_load(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    endtask

    // Switches move in mid-load; the load must keep its captured values.
    task automatic t_button_still();
        @(posedge core_clk);
        sensor_variant_switch <= 1'b0;
        channel_count_switch <= 1'b1;
        capture_mode_switch <= 1'b1;
        integration_select_inputs <= 5'h03;
        i_far.words.delete();
        @(posedge core_clk);
        reset_pushbutton <= 1'b1;
        wait_busy();
        @(posedge core_clk);
        reset_pushbutton <= 1'b0;
        sensor_variant_switch <= 1'b1;
        channel_count_switch <= 1'b0;
        integration_select_inputs <= 5'h05;
        wait_done();
        check_load(1'b0, 1'b1, 1'b0, 1'b1, 3'h3);
    endtask

    task automatic t_remote_bin();
        @(posedge core_clk);
        remote_reset_input <= 1'b1;
        binning_select_switch <= 1'b1;
        capture_mode_switch <= 1'b0;
        integration_select_inputs <= 5'h07;
        repeat (6) @(negedge core_clk);
        check("generator reset", 34'h0, {33'h0, timing_gen_async_reset_n});
        i_far.words.delete();
        @(posedge core_clk);
        remote_reset_input <= 1'b0;
        wait_busy();
        wait_done();
        check_load(1'b1, 1'b0, 1'b1, 1'b0, 3'h7);
    endtask

    task automatic t_power_good();
        @(posedge core_clk);
        power_good_delayed <= 1'b0;
        binning_select_switch <= 1'b0;
        channel_count_switch <= 1'b1;
        integration_select_inputs <= 5'h04;
        repeat (5) @(posedge core_clk);
        i_far.words.delete();
        power_good_delayed <= 1'b1;
        wait_busy();
        wait_done();
        check_load(1'b1, 1'b1, 1'b0, 1'b0, 3'h4);
    endtask

    // After loading, activity is flagged and host serial lines pass on.
    task automatic t_after_load();
        int n;
        for (n = 0; n < 40 && tg_active !== 1'b1; n++) @(negedge core_clk);
        check("activity", 34'h1, {33'h0, tg_active});
        @(posedge core_clk);
        host_sload <= 1'b0;
        host_sdata <= 1'b1;
        host_sclock <= 1'b1;
        repeat (6) @(negedge core_clk);
        check("host pass", 34'h3, {32'h0, sdata, sclock});
        @(posedge core_clk);
        host_sdata <= 1'b0;
        host_sclock <= 1'b0;
        repeat (6) @(negedge core_clk);
        check("host pass", 34'h0, {32'h0, sdata, sclock});
        @(posedge core_clk);
        host_sload <= 1'b1;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        i_far.words.delete();
        t_power_up();
        t_after_load();
        t_button_still();
        t_remote_bin();
        t_power_good();
        print_verdict();
    end
endmodule

bind imager_board_default_loader loader_monitor i_mon (
    .core_clk(core_clk), .nrst(nrst),
    .power_good_delayed(power_good_delayed),
    .reset_pushbutton(reset_pushbutton),
    .remote_reset_input(remote_reset_input), .sclock(sclock),
    .sload_afe1_n(sload_afe1_n), .sload_afe2_n(sload_afe2_n),
    .sload_tg_n(sload_tg_n),
    .timing_gen_async_reset_n(timing_gen_async_reset_n),
    .pixel_data_clock(pixel_data_clock), .load_busy(load_busy),
    .load_done(load_done), .tg_active(tg_active));
